//--- rtl/acc_conv_ctrl.sv
`timescale 1ns/1ps

module acc_conv_ctrl
    import acc_pkg::*;
#(
    parameter int SET_CYC    = SET_CYCLES,
    parameter int PERIOD_CYC = PERIOD_CYCLES
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Register port from the serial host engine
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [15:0]       reg_wdata_i,
    output logic [15:0]            reg_rdata_o,
    // Power mode pin
    input  wire logic              low_power_i,
    // Converter front end
    input  wire logic [RES_W-1:0]  adc_data_i,
    output logic                   adc_enable_o,
    output logic                   conv_start_o,
    output logic [CH_W-1:0]        channel_o,
    output logic                   input_range_select_o,
    // Result register update
    output logic                   result_wr_o,
    output logic [CH_W-1:0]        result_ch_o,
    output logic [RES_W-1:0]       result_data_o
);

    // ----------------------------------------------------------------
    // Timing counts
    // ----------------------------------------------------------------
    localparam int             CH_CYC     = (SET_CYC / NUM_CH < 1) ? 1 : SET_CYC / NUM_CH;
    localparam logic [TMR_W-1:0] CH_LOAD  = TMR_W'(CH_CYC - 1);
    localparam logic [TMR_W-1:0] PER_LAST = TMR_W'(PERIOD_CYC - 1);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [15:0]       opt_q,      opt_d;
    logic              lp_s1_q,    lp_s2_q;
    logic [RES_W-1:0]  dat_s1_q,   dat_s2_q;
    acc_state_t        state_q,    state_d;
    logic [CH_W-1:0]   ch_q,       ch_d;
    logic [TMR_W-1:0]  tmr_q,      tmr_d;
    logic [TMR_W-1:0]  per_q,      per_d;
    logic              start_q,    start_d;
    logic              wr_q,       wr_d;
    logic [CH_W-1:0]   res_ch_q;
    logic [RES_W-1:0]  res_dat_q;
    logic [15:0]       rdata_q;
    logic              set_done;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire              hit_opt   = (reg_addr_i == ADDR_OPTION);
    wire              host_wr   = reg_wr_i && hit_opt;
    wire              repeat_on = opt_q[BIT_REPEAT];
    wire              trig_on   = opt_q[BIT_TRIGGER];
    wire              go        = trig_on && !lp_s2_q;
    wire [NUM_CH-1:0] en_mask   = opt_q[EN_HI:0];
    wire [CH_W:0]     pick_from = (state_q == ST_CONV) ? ({1'b0, ch_q} + 4'h1) : 4'h0;
    wire              pick_found;
    wire [CH_W-1:0]   pick_idx;

    acc_chan_pick u_pick (
        .mask_i  (en_mask),
        .from_i  (pick_from),
        .found_o (pick_found),
        .idx_o   (pick_idx)
    );

    // ----------------------------------------------------------------
    // Option register
    // ----------------------------------------------------------------
    always_comb begin
        opt_d = opt_q;
        if (set_done && !repeat_on) begin
            opt_d[BIT_TRIGGER] = 1'b0;
        end
        // A host write in the same cycle overrides the self-clear
        if (host_wr) begin
            opt_d = reg_wdata_i & OPTION_WMASK;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            opt_q <= OPTION_RESET;
        end else begin
            opt_q <= opt_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd_i) begin
            rdata_q <= hit_opt ? opt_q : 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lp_s1_q  <= 1'b0;
            lp_s2_q  <= 1'b0;
            dat_s1_q <= '0;
            dat_s2_q <= '0;
        end else begin
            lp_s1_q  <= low_power_i;
            lp_s2_q  <= lp_s1_q;
            dat_s1_q <= adc_data_i;
            dat_s2_q <= dat_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_d  = state_q;
        ch_d     = ch_q;
        tmr_d    = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
        per_d    = (per_q != PER_LAST) ? per_q + 1'b1 : per_q;
        start_d  = 1'b0;
        wr_d     = 1'b0;
        set_done = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (go) begin
                    per_d = '0;
                    if (pick_found) begin
                        state_d = ST_CONV;
                        ch_d    = pick_idx;
                        tmr_d   = CH_LOAD;
                        start_d = 1'b1;
                    end else begin
                        set_done = 1'b1;
                        state_d  = repeat_on ? ST_WAIT : ST_IDLE;
                    end
                end
            end
            ST_CONV: begin
                if (!go) begin
                    state_d = ST_IDLE;
                end else if (tmr_q == '0) begin
                    wr_d = 1'b1;
                    if (pick_found) begin
                        ch_d    = pick_idx;
                        tmr_d   = CH_LOAD;
                        start_d = 1'b1;
                    end else begin
                        set_done = 1'b1;
                        state_d  = repeat_on ? ST_WAIT : ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                if (!go) begin
                    state_d = ST_IDLE;
                end else if (per_q == PER_LAST) begin
                    per_d = '0;
                    if (pick_found) begin
                        state_d = ST_CONV;
                        ch_d    = pick_idx;
                        tmr_d   = CH_LOAD;
                        start_d = 1'b1;
                    end else begin
                        set_done = 1'b1;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            ch_q    <= '0;
            tmr_q   <= '0;
            per_q   <= '0;
            start_q <= 1'b0;
            wr_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            ch_q    <= ch_d;
            tmr_q   <= tmr_d;
            per_q   <= per_d;
            start_q <= start_d;
            wr_q    <= wr_d;
        end
    end

    // Result capture: only the channel just converted is written
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            res_ch_q  <= '0;
            res_dat_q <= '0;
        end else if (wr_d) begin
            res_ch_q  <= ch_q;
            res_dat_q <= dat_s2_q;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata_o          = rdata_q;
    assign adc_enable_o         = (state_q == ST_CONV) && !lp_s2_q;
    assign conv_start_o         = start_q;
    assign channel_o            = ch_q;
    assign input_range_select_o = opt_q[BIT_RANGE];
    assign result_wr_o          = wr_q;
    assign result_ch_o          = res_ch_q;
    assign result_data_o        = res_dat_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0] en_prev_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            en_prev_q <= '0;
        end else begin
            en_prev_q <= en_mask;
        end
    end

    wire last_slot = (state_q == ST_CONV) && go && (tmr_q == '0) && !pick_found && !host_wr;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_seq_ascend: assert property (conv_start_o && $past(state_q) == ST_CONV |-> ch_q > $past(ch_q))
        else $error("channel order not ascending");
    chk_lowpower_stop: assert property (lp_s2_q |=> state_q == ST_IDLE && !conv_start_o)
        else $error("conversion active in low power");
    chk_slot_load: assert property (conv_start_o |-> tmr_q == CH_LOAD)
        else $error("channel slot length wrong");
    chk_oneshot_end: assert property (last_slot && !repeat_on |=> state_q == ST_IDLE && !trig_on)
        else $error("one-shot did not stop and clear trigger");
    chk_repeat_wait: assert property (last_slot && repeat_on |=> state_q == ST_WAIT && trig_on)
        else $error("continuous mode did not wait for period");
    chk_period_start: assert property (state_q == ST_WAIT && go && per_q == PER_LAST |=> per_q == '0)
        else $error("period restart missed");
    chk_range_write: assert property (host_wr |=> input_range_select_o == $past(reg_wdata_i[BIT_RANGE]))
        else $error("range select not taken from write");
    chk_reserved_zero: assert property (opt_q[RSVD_HI:RSVD_LO] == 5'h00)
        else $error("reserved option bits nonzero");
    chk_enabled_only: assert property (conv_start_o |-> en_prev_q[ch_q])
        else $error("disabled channel converted");
    chk_write_source: assert property (result_wr_o |-> $past(state_q) == ST_CONV ##1 !result_wr_o)
        else $error("result written outside conversion");

endmodule : acc_conv_ctrl

//--- rtl/acc_pkg.sv
package acc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  ADDR_OPTION  = 8'h35;
    localparam logic [15:0] OPTION_RESET = 16'h2000;
    localparam int          BIT_REPEAT   = 15;
    localparam int          BIT_TRIGGER  = 14;
    localparam int          BIT_RANGE    = 13;
    localparam int          RSVD_HI      = 12;
    localparam int          RSVD_LO      = 8;
    localparam int          EN_HI        = 7;
    localparam logic [15:0] OPTION_WMASK = 16'he0ff;

    // ----------------------------------------------------------------
    // Channels, ascending index is the conversion sequence
    // ----------------------------------------------------------------
    localparam int NUM_CH = 8;
    localparam int CH_W   = 3;
    localparam int RES_W  = 16;
    typedef enum logic [2:0] {
        CH_BATTERY_VOLTAGE   = 3'h0,
        CH_SYSTEM_VOLTAGE    = 3'h1,
        CH_CHARGE_CURRENT    = 3'h2,
        CH_DISCHARGE_CURRENT = 3'h3,
        CH_INPUT_CURRENT     = 3'h4,
        CH_SYSTEM_POWER      = 3'h5,
        CH_BUS_VOLTAGE       = 3'h6,
        CH_COMPARATOR_INPUT  = 3'h7
    } acc_chan_t;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ        = 10_000_000;
    localparam int SET_TIME_MS   = 10;
    localparam int PERIOD_TIME_S = 1;
    localparam int SET_CYCLES    = CLK_HZ / 1000 * SET_TIME_MS;
    localparam int PERIOD_CYCLES = CLK_HZ * PERIOD_TIME_S;
    localparam int TMR_W         = 24;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_CONV = 3'h2,
        ST_WAIT = 3'h4
    } acc_state_t;

endpackage : acc_pkg

//--- rtl/acc_chan_pick.sv
`timescale 1ns/1ps

module acc_chan_pick
    import acc_pkg::*;
(
    // Enable mask and search start (NUM_CH means none left)
    input  wire logic [NUM_CH-1:0] mask_i,
    input  wire logic [CH_W:0]     from_i,
    // Result
    output logic                   found_o,
    output logic [CH_W-1:0]        idx_o
);

    // First enabled channel at or above from_i, lowest index first
    always_comb begin
        found_o = 1'b0;
        idx_o   = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (mask_i[i] && (i >= int'(from_i))) begin
                found_o = 1'b1;
                idx_o   = CH_W'(i);
            end
        end
    end

endmodule : acc_chan_pick

//--- verif/acc_adc_model.sv
`timescale 1ns/1ps

module acc_adc_model
    import acc_pkg::*;
(
    // Clock
    input  wire logic             clk_i,
    // Converter control from the block
    input  wire logic             adc_enable_i,
    input  wire logic             conv_start_i,
    input  wire logic [CH_W-1:0]  channel_i,
    // Sample base chosen by the bench
    input  wire logic [RES_W-1:0] base_i,
    // Result pins
    output logic      [RES_W-1:0] adc_data_o
);
    initial adc_data_o = '0;

    // Each slot presents base xor channel; idle pins churn so stale values never look valid
    always @(posedge clk_i) begin
        if (adc_enable_i && conv_start_i) begin
            adc_data_o <= base_i ^ RES_W'(channel_i);
        end else if (!adc_enable_i) begin
            adc_data_o <= ~adc_data_o;
        end
    end
endmodule : acc_adc_model

//--- verif/tb.sv
`timescale 1ns/1ps

module tb
    import acc_pkg::*;
;
    localparam int SETC = 64;
    localparam int PERC = 1000;
    localparam int CHC  = SETC / 8;

    logic             clk_i;
    logic             rst_i;
    logic             reg_wr_i;
    logic             reg_rd_i;
    logic             low_power_i;
    logic [7:0]       reg_addr_i;
    logic [15:0]      reg_wdata_i;
    logic [15:0]      reg_rdata_o;
    logic [15:0]      base;
    logic [RES_W-1:0] adc_data_i;
    logic [RES_W-1:0] result_data_o;
    logic             adc_enable_o;
    logic             conv_start_o;
    logic             input_range_select_o;
    logic             result_wr_o;
    logic [CH_W-1:0]  channel_o;
    logic [CH_W-1:0]  result_ch_o;
    logic [18:0]      got_q[$];
    int               cyc_q[$];
    int               error_cnt;
    int               n_checks;
    int               cyc = 0;
    logic [15:0]      d;
    int               k;

    acc_conv_ctrl #(.SET_CYC(SETC), .PERIOD_CYC(PERC)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .low_power_i(low_power_i), .adc_data_i(adc_data_i), .adc_enable_o(adc_enable_o),
        .conv_start_o(conv_start_o), .channel_o(channel_o),
        .input_range_select_o(input_range_select_o), .result_wr_o(result_wr_o),
        .result_ch_o(result_ch_o), .result_data_o(result_data_o));

    acc_adc_model u_adc (
        .clk_i(clk_i), .adc_enable_i(adc_enable_o), .conv_start_i(conv_start_o),
        .channel_i(channel_o), .base_i(base), .adc_data_o(adc_data_i));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i) cyc <= cyc + 1;

    // Log every result update with its cycle
    always @(negedge clk_i) begin
        if (result_wr_o === 1'b1) begin
            got_q.push_back({result_ch_o, result_data_o});
            cyc_q.push_back(cyc);
        end
    end

    // ------------------------------------------------------------
    // Bench tasks
    // ------------------------------------------------------------
    task finish_test;
        if (error_cnt == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task cmp_reg(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
        end
    endtask : cmp_reg

    task cmp_res(input logic [18:0] got, input logic [18:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t result %h expected %h", $time, got, exp);
        end
    endtask : cmp_res

    task wr(input logic [7:0] a, input logic [15:0] v);
        @(negedge clk_i);
        reg_addr_i  = a;
        reg_wdata_i = v;
        reg_wr_i    = 1'b1;
        @(negedge clk_i);
        reg_wr_i    = 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [15:0] v);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_rd_i   = 1'b1;
        @(negedge clk_i);
        reg_rd_i   = 1'b0;
        @(negedge clk_i);
        v = reg_rdata_o;
    endtask : rd

    task wait_res(input int n, input int lim);
        for (int i = 0; i < lim && got_q.size() < n; i++) @(negedge clk_i);
    endtask : wait_res

    // One-shot set with reserved bits written high; range pick may follow the low-input advice
    task oneshot(input logic [7:0] m, input logic r);
        int n;
        int j;
        got_q.delete();
        cyc_q.delete();
        base = 16'($urandom);
        wr(8'h35, {2'b01, r, 5'h1f, m});
        n = $countones(m);
        wait_res(n, 12 * CHC);
        repeat (3 * CHC) @(negedge clk_i);
        cmp_reg(16'(got_q.size()), 16'(n));
        j = 0;
        for (int c = 0; c < 8; c++) begin
            if (m[c]) begin
                cmp_res(got_q[j], {3'(c), base ^ 16'(c)});
                if (j > 0) cmp_reg(16'(cyc_q[j] - cyc_q[j-1]), 16'(CHC));
                j++;
            end
        end
        rd(8'h35, d);
        cmp_reg(d, {2'b00, r, 5'h00, m});
        cmp_reg(16'(input_range_select_o), 16'(r));
    endtask : oneshot

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_i, reg_wr_i, reg_rd_i, low_power_i} = 4'h8;
        reg_addr_i  = 8'h00;
        reg_wdata_i = 16'h0000;
        base        = 16'h0000;
        error_cnt   = 0;
        n_checks    = 0;
        void'($urandom(32'hf18aa37e));
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        rd(8'h35, d);
        cmp_reg(d, 16'h2000);
        cmp_reg(16'(input_range_select_o), 16'h0001);
        wr(8'h34, 16'hffff);
        rd(8'h35, d);
        cmp_reg(d, 16'h2000);
        rd(8'h34, d);
        cmp_reg(d, 16'h0000);
        wr(8'h35, 16'h1fff);
        rd(8'h35, d);
        cmp_reg(d, 16'h00ff);
        cmp_reg(16'(input_range_select_o), 16'h0000);
        oneshot(8'hff, 1'b1);
        oneshot(8'h05, 1'b0);
        oneshot(8'h80, 1'b0);
        repeat (4) oneshot(8'($urandom_range(1, 255)), 1'($urandom));
        // Trigger while in low power, then leave it
        low_power_i = 1'b1;
        got_q.delete();
        wr(8'h35, 16'h4001);
        repeat (100) @(negedge clk_i);
        cmp_reg(16'(got_q.size()), 16'h0000);
        cmp_reg(16'(adc_enable_o), 16'h0000);
        low_power_i = 1'b0;
        wait_res(1, 4 * CHC);
        repeat (CHC) @(negedge clk_i);
        cmp_reg(16'(got_q.size()), 16'h0001);
        cmp_res(got_q[0], {3'h0, base});
        // Low power in mid-set aborts; leaving it runs a whole set again
        wr(8'h35, 16'h40ff);
        repeat (2 * CHC) @(negedge clk_i);
        low_power_i = 1'b1;
        repeat (4) @(negedge clk_i);
        got_q.delete();
        repeat (4 * CHC) @(negedge clk_i);
        cmp_reg(16'(got_q.size()), 16'h0000);
        cmp_reg(16'(adc_enable_o), 16'h0000);
        low_power_i = 1'b0;
        wait_res(8, 12 * CHC);
        repeat (3 * CHC) @(negedge clk_i);
        cmp_reg(16'(got_q.size()), 16'h0008);
        cmp_res(got_q[0], {3'h0, base});
        rd(8'h35, d);
        cmp_reg(d, 16'h00ff);
        // One-shot with no channel enabled: trigger clears, nothing written
        got_q.delete();
        wr(8'h35, 16'h6000);
        repeat (4) @(negedge clk_i);
        rd(8'h35, d);
        cmp_reg(d, 16'h2000);
        cmp_reg(16'(got_q.size()), 16'h0000);
        // Continuous sets
        got_q.delete();
        cyc_q.delete();
        wr(8'h35, 16'hc081);
        wait_res(4, PERC + 20 * CHC);
        for (k = 0; k < 4; k++) cmp_res(got_q[k], {k[0] ? 3'h7 : 3'h0, base ^ (k[0] ? 16'h7 : 16'h0)});
        cmp_reg(16'(cyc_q[2] - cyc_q[0]), 16'(PERC));
        cmp_reg(16'(cyc_q[1] - cyc_q[0]), 16'(CHC));
        rd(8'h35, d);
        cmp_reg(d, 16'hc081);
        wr(8'h35, 16'h0000);
        got_q.delete();
        repeat (PERC + 50) @(negedge clk_i);
        cmp_reg(16'(got_q.size()), 16'h0000);
        finish_test();
    end

    initial begin
        #(20000 * 100);
        error_cnt++;
        finish_test();
    end
endmodule : tb
